/* hw/iap_flash_ctrl.sv */
// Flash erase, write and read sequencer with its APB register file.
// Assumes a flash macro that answers a held request with a one-cycle done.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module iap_flash_ctrl #(
  parameter int PAGE_MODE  = 0,
  parameter int PAGE_WORDS = 32,
  parameter int ADDR_W     = 12
) (
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  output iap_pkg::iap_flash_cmd_t      flash_cmd,
  input  wire iap_pkg::iap_flash_rsp_t flash_rsp
);
  import iap_pkg::*;

  localparam int UNIT_W  = (PAGE_MODE != 0) ? $clog2(PAGE_WORDS) : UNIT_BITS;
  localparam int ERASE_W = (PAGE_MODE != 0) ? UNIT_W : BLOCK_BITS;
  localparam logic [UNIT_W-1:0] UNIT_LAST = '1;

  iap_state_t         state;
  logic               unlocked;
  logic [2:0]         op_sel;
  logic               write_trig;
  logic               read_en;
  logic               read_trig;
  logic [7:0]         key;
  logic               clr_pend;
  logic [ADDR_W-1:0]  addr;
  logic [7:0]         data_lo;
  logic [7:0]         data_hi;
  logic [15:0]        wbuf [PAGE_WORDS];
  logic [UNIT_W-1:0]  cnt;
  logic               access;
  logic               wr;
  logic               mapped;
  logic               busy;
  logic               seq_done;
  logic               prog_done;
  logic               data_ok;
  logic [2:0]         next_op;
  logic [ADDR_W-1:0]  unit_base;
  logic [ADDR_W-1:0]  erase_base;

  assign access    = psel && penable;
  assign wr        = access && pwrite;
  assign pready    = 1'b1;
  assign pslverr   = access && !mapped;
  assign busy      = (state != ST_IDLE) || write_trig || read_trig;
  assign seq_done  = (state != ST_IDLE) && flash_rsp.done &&
                     ((state != ST_PROG) || (cnt == UNIT_LAST));
  assign prog_done = seq_done && (state == ST_PROG);
  // Data loads are refused while locked and while a sequence owns the buffer.
  assign data_ok   = unlocked && !busy;
  assign next_op   = pwdata[CTRL_OP_LSB+2:CTRL_OP_LSB];
  assign unit_base  = {addr[ADDR_W-1:UNIT_W], {UNIT_W{1'b0}}};
  // Block variant: low eight address bits are ignored for the block select.
  assign erase_base = {addr[ADDR_W-1:ERASE_W], {ERASE_W{1'b0}}};

  always_comb begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      REG_CTRL: begin
        prdata[CTRL_UNLOCKED] = unlocked;
        prdata[CTRL_OP_LSB+2:CTRL_OP_LSB] = op_sel;
        prdata[CTRL_WRITE] = write_trig;
        prdata[CTRL_READ_EN] = read_en;
        prdata[CTRL_READ] = read_trig;
      end
      REG_KEY:      prdata[7:0] = key;
      REG_BUF_CTRL: prdata[0] = clr_pend;
      REG_ADDR_LO:  prdata[7:0] = addr[7:0];
      REG_ADDR_HI:  prdata[ADDR_W-9:0] = addr[ADDR_W-1:8];
      REG_DATA_LO:  prdata[7:0] = data_lo;
      REG_DATA_HI:  prdata[7:0] = data_hi;
      default:      mapped = 1'b0;
    endcase
  end

  // Unlock status: only the enable procedure sets it, software only clears.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      unlocked <= 1'b0;
    end else if (wr && paddr == REG_CTRL && !busy) begin
      if (pwdata[CTRL_UNLOCK_GO] && next_op == OP_UNLOCK &&
          key == UNLOCK_KEY) begin
        unlocked <= 1'b1;
      end else if (!pwdata[CTRL_UNLOCKED]) begin
        unlocked <= 1'b0;
      end
    end
  end

  // Control fields and the two triggers.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      op_sel     <= OP_WRITE;
      read_en    <= 1'b0;
      write_trig <= 1'b0;
      read_trig  <= 1'b0;
    end else if (seq_done) begin
      write_trig <= 1'b0;
      read_trig  <= 1'b0;
    end else if (wr && paddr == REG_CTRL && !busy) begin
      op_sel  <= next_op;
      read_en <= pwdata[CTRL_READ_EN];
      // A write or erase trigger while locked is dropped on the floor.
      write_trig <= pwdata[CTRL_WRITE] && unlocked &&
                    (next_op == OP_WRITE || next_op == OP_ERASE);
      // Reading needs the enable bit in the same write; the stored read_en is not consulted.
      read_trig <= pwdata[CTRL_READ] && pwdata[CTRL_READ_EN] &&
                   next_op == OP_READ;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      key <= 8'h00;
    end else if (wr && paddr == REG_KEY) begin
      key <= pwdata[7:0];
    end
  end

  // Buffer clear command takes one cycle and then reads back as zero.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      clr_pend <= 1'b0;
    end else if (clr_pend) begin
      clr_pend <= 1'b0;
    end else if (wr && paddr == REG_BUF_CTRL && !busy) begin
      clr_pend <= pwdata[0];
    end
  end

  // Address register; a data high load steps it but never past the unit end.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      addr <= '0;
    end else if (wr && !busy) begin
      if (paddr == REG_ADDR_LO) begin
        addr[7:0] <= pwdata[7:0];
      end else if (paddr == REG_ADDR_HI) begin
        addr[ADDR_W-1:8] <= pwdata[ADDR_W-9:0];
      end else if (paddr == REG_DATA_HI && data_ok &&
                   addr[UNIT_W-1:0] != UNIT_LAST) begin
        addr <= addr + 1'b1;
      end
    end
  end

  // Data registers; a finished read overwrites them with the flash word.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      data_lo <= 8'h00;
      data_hi <= 8'h00;
    end else if (seq_done && state == ST_READ) begin
      data_lo <= flash_rsp.rdata[7:0];
      data_hi <= flash_rsp.rdata[15:8];
    end else if (wr && data_ok && paddr == REG_DATA_LO) begin
      data_lo <= pwdata[7:0];
    end else if (wr && data_ok && paddr == REG_DATA_HI) begin
      data_hi <= pwdata[7:0];
    end
  end

  // Write buffer; indexed by the word offset inside the current unit.
  always_ff @(posedge core_clk) begin
    if (!reset_n || clr_pend || prog_done) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        wbuf[i] <= BUF_CLEAR_VALUE;
      end
    end else if (wr && data_ok && paddr == REG_DATA_HI) begin
      wbuf[addr[UNIT_W-1:0]] <= {pwdata[7:0], data_lo};
    end
  end

  // Sequencer. The request stays up until the macro answers with done.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state     <= ST_IDLE;
      cnt       <= '0;
      flash_cmd <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          cnt <= '0;
          if (write_trig && op_sel == OP_ERASE) begin
            state           <= ST_ERASE;
            flash_cmd.valid <= 1'b1;
            flash_cmd.op    <= FOP_ERASE;
            flash_cmd.addr  <= 16'(erase_base);
            flash_cmd.wdata <= 16'h0000;
          end else if (write_trig) begin
            state           <= ST_PROG;
            flash_cmd.valid <= 1'b1;
            flash_cmd.op    <= FOP_PROG;
            flash_cmd.addr  <= 16'(unit_base);
            flash_cmd.wdata <= wbuf[0];
          end else if (read_trig) begin
            state           <= ST_READ;
            flash_cmd.valid <= 1'b1;
            flash_cmd.op    <= FOP_READ;
            flash_cmd.addr  <= 16'(addr);
            flash_cmd.wdata <= 16'h0000;
          end
        end
        ST_PROG: begin
          if (flash_rsp.done) begin
            // Four words in the block variant, a whole page otherwise.
            if (cnt == UNIT_LAST) begin
              state           <= ST_IDLE;
              flash_cmd.valid <= 1'b0;
            end else begin
              cnt             <= cnt + 1'b1;
              flash_cmd.addr  <= flash_cmd.addr + 16'h0001;
              flash_cmd.wdata <= wbuf[cnt + 1'b1];
            end
          end
        end
        ST_ERASE, ST_READ: begin
          if (flash_rsp.done) begin
            state           <= ST_IDLE;
            flash_cmd.valid <= 1'b0;
          end
        end
        default: begin
          state           <= ST_IDLE;
          flash_cmd.valid <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* include/iap_pkg.sv */
// Package for the in-application flash update controller.
// Assumes an APB master on core_clk and a flash macro with a level request.
package iap_pkg;

  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_KEY      = 8'h04;
  localparam logic [7:0] REG_BUF_CTRL = 8'h08;
  localparam logic [7:0] REG_ADDR_LO  = 8'h0C;
  localparam logic [7:0] REG_ADDR_HI  = 8'h10;
  localparam logic [7:0] REG_DATA_LO  = 8'h14;
  localparam logic [7:0] REG_DATA_HI  = 8'h18;

  localparam int CTRL_UNLOCKED = 7;
  localparam int CTRL_OP_LSB   = 4;
  localparam int CTRL_UNLOCK_GO = 3;
  localparam int CTRL_WRITE    = 2;
  localparam int CTRL_READ_EN  = 1;
  localparam int CTRL_READ     = 0;

  localparam logic [2:0] OP_WRITE  = 3'h0;
  localparam logic [2:0] OP_ERASE  = 3'h1;
  localparam logic [2:0] OP_READ   = 3'h3;
  localparam logic [2:0] OP_UNLOCK = 3'h6;

  // Arbitrary key value that the enable procedure expects in the key register.
  localparam logic [7:0] UNLOCK_KEY = 8'hA5;

  localparam int BLOCK_BITS = 8;
  localparam int UNIT_BITS  = 2;
  localparam logic [15:0] BUF_CLEAR_VALUE = 16'h0000;

  localparam logic [1:0] FOP_READ  = 2'h0;
  localparam logic [1:0] FOP_PROG  = 2'h1;
  localparam logic [1:0] FOP_ERASE = 2'h2;

  typedef struct packed {
    logic        valid;
    logic [1:0]  op;
    logic [15:0] addr;
    logic [15:0] wdata;
  } iap_flash_cmd_t;

  typedef struct packed {
    logic        done;
    logic [15:0] rdata;
  } iap_flash_rsp_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ERASE = 4'b0010,
    ST_PROG  = 4'b0100,
    ST_READ  = 4'b1000
  } iap_state_t;

endpackage

/* verification/iap_flash_ctrl_checker.sv */
// Port checker for the flash update controller.
// Assumes a bind onto iap_flash_ctrl from the bench top file.
`timescale 1ns/100ps
`default_nettype none
module iap_flash_ctrl_checker #(
  parameter int PAGE_MODE  = 0,
  parameter int PAGE_WORDS = 32
) (
  input wire logic                    core_clk,
  input wire logic                    reset_n,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire iap_pkg::iap_flash_cmd_t flash_cmd,
  input wire iap_pkg::iap_flash_rsp_t flash_rsp
);
  import iap_pkg::*;
  // A page spans the buffer; the block variant writes four words.
  localparam logic [15:0] UM = PAGE_MODE ? 16'(PAGE_WORDS - 1) : 16'h0003;
  localparam logic [15:0] EM = PAGE_MODE ? UM : 16'h00FF;
  logic        go;
  logic        prg;
  logic [15:0] ad;
  assign go = flash_cmd.valid && flash_rsp.done;
  assign prg = flash_cmd.op == FOP_PROG;
  assign ad = flash_cmd.addr;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ready_always_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (psel && penable &&
    (paddr[1:0] != 2'h0 || paddr > REG_DATA_HI) |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  cmd_hold_a: assert property (
    flash_cmd.valid && !flash_rsp.done |=> $stable(flash_cmd))
    else $error("flash request moved before done");
  erase_align_a: assert property (
    flash_cmd.valid && flash_cmd.op == FOP_ERASE |-> (ad & EM) == 0)
    else $error("erase address not aligned");
  prog_step_a: assert property (go && prg && (ad & UM) != UM |=>
    flash_cmd.valid && prg && ad == $past(ad) + 16'h1)
    else $error("program did not step");
  prog_last_a: assert property (go && prg && (ad & UM) == UM
    |=> !flash_cmd.valid) else $error("program overran unit");
  prog_start_a: assert property ($rose(flash_cmd.valid) && prg
    |-> (ad & UM) == 0) else $error("program unit base wrong");
  read_start_a: assert property (psel && penable && pwrite &&
    paddr == REG_CTRL && pwdata[6:0] == 7'h33 && !flash_cmd.valid
    |-> ##2 flash_cmd.valid && flash_cmd.op == FOP_READ)
    else $error("read not started");
endmodule
`default_nettype wire

/* verification/iap_flash_ctrl_tb_top.sv */
// Bench top for the flash update controller, block variant.
// Assumes the bench is both the APB master and the flash macro.
`timescale 1ns/100ps
`default_nettype none
module iap_flash_ctrl_tb_top;
  import iap_pkg::*;
  logic           core_clk;
  logic           reset_n;
  logic           psel, penable, pwrite, pready, pslverr;
  logic [7:0]     paddr, lo, hi;
  logic [31:0]    pwdata, prdata;
  iap_flash_cmd_t flash_cmd;
  iap_flash_rsp_t flash_rsp;
  logic [33:0]    q[$];
  logic [15:0]    rd_word, dw[3];
  int             n_mismatch, tests_run, n_done, n_exp, cnt, lim;
  iap_flash_ctrl #(.PAGE_MODE(0), .PAGE_WORDS(32), .ADDR_W(12)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_cmd(flash_cmd),
    .flash_rsp(flash_rsp));
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic take(input logic [33:0] seen);
    if (q.size() == 0) begin
      // A result with no note is a mismatch even when it is unknown.
      tests_run++;
      n_mismatch++;
      $display("unexpected at %0t: result %h with nothing expected", $time,
               seen);
    end else begin
      check(seen, q.pop_front());
    end
  endtask
  // Write data is only defined while programming, so it is masked.
  always @(posedge core_clk) begin
    if (flash_cmd.valid && flash_rsp.done) begin
      n_done++;
      take({flash_cmd.op, flash_cmd.addr, prgd(flash_cmd)});
    end
    if (psel && penable && !pwrite) take({1'b0, pslverr, prdata});
  end
  function automatic logic [15:0] prgd(input iap_flash_cmd_t c);
    return c.op == FOP_PROG ? c.wdata : 16'h0;
  endfunction
  // Flash stand-in answers 4 to 7 cycles after the request; rdata is junk off done.
  always @(posedge core_clk) begin
    cnt <= (flash_cmd.valid && !flash_rsp.done) ? cnt + 1 : 0;
    flash_rsp.done <= flash_cmd.valid && !flash_rsp.done && cnt == lim;
    flash_rsp.rdata <= (cnt == lim) ? rd_word : ~rd_word;
    if (flash_rsp.done) lim <= $urandom_range(6, 3);
  end
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'($urandom), d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic e = 0);
    q.push_back({1'b0, e, 24'h0, d});
    apb(a, 1'b0, 8'h0);
  endtask
  task automatic fx(input logic [1:0] o, input logic [15:0] a, input logic [15:0] d);
    q.push_back({o, a, d});
    n_exp++;
  endtask
  task automatic wait_done();
    repeat (100) if (n_done < n_exp) @(posedge core_clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
    flash_rsp = '0;
    rd_word = '0;
    cnt = 0;
    lim = 3;
    void'($urandom(32'h1750FB56));
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(REG_CTRL, 8'h00);
    rd(8'h1C, 8'h00, 1'b1);
    wr(REG_CTRL, 8'h84);
    wr(REG_DATA_LO, 8'h5A);
    rd(REG_CTRL, 8'h00);
    rd(REG_DATA_LO, 8'h00);
    $display("lock test done");
    wr(REG_KEY, UNLOCK_KEY);
    wr(REG_CTRL, {1'b0, OP_UNLOCK, 4'h8});
    rd(REG_CTRL, {1'b1, OP_UNLOCK, 4'h0});
    hi = 8'($urandom_range(15, 0));
    lo = 8'($urandom);
    wr(REG_ADDR_HI, hi);
    wr(REG_ADDR_LO, lo);
    wr(REG_CTRL, {1'b1, OP_ERASE, 4'h4});
    rd(REG_CTRL, {1'b1, OP_ERASE, 4'h4});
    fx(FOP_ERASE, {4'h0, hi[3:0], 8'h00}, 16'h0);
    wait_done();
    rd(REG_CTRL, {1'b1, OP_ERASE, 4'h0});
    $display("erase test done");
    wr(REG_BUF_CTRL, 8'h01);
    lo = {lo[7:2], 2'b10};
    wr(REG_ADDR_LO, lo);
    foreach (dw[i]) begin
      dw[i] = 16'($urandom);
      wr(REG_DATA_LO, dw[i][7:0]);
      wr(REG_DATA_HI, dw[i][15:8]);
    end
    rd(REG_ADDR_LO, {lo[7:2], 2'b11});
    wr(REG_CTRL, {1'b1, OP_WRITE, 4'h4});
    rd(REG_CTRL, {1'b1, OP_WRITE, 4'h4});
    for (int i = 0; i < 4; i++)
      fx(FOP_PROG, {4'h0, hi[3:0], lo[7:2], 2'(i)},
        i == 2 ? dw[0] : i == 3 ? dw[2] : 16'h0);
    wait_done();
    rd(REG_CTRL, {1'b1, OP_WRITE, 4'h0});
    $display("program test done");
    rd_word = 16'($urandom);
    wr(REG_ADDR_LO, lo);
    wr(REG_CTRL, {1'b1, OP_READ, 4'h1});
    rd(REG_CTRL, {1'b1, OP_READ, 4'h0});
    wr(REG_CTRL, {1'b1, OP_READ, 4'h3});
    rd(REG_CTRL, {1'b1, OP_READ, 4'h3});
    fx(FOP_READ, {4'h0, hi[3:0], lo}, 16'h0);
    wait_done();
    rd(REG_CTRL, {1'b1, OP_READ, 4'h2});
    rd(REG_DATA_LO, rd_word[7:0]);
    rd(REG_DATA_HI, rd_word[15:8]);
    wr(REG_CTRL, 8'h00);
    rd(REG_CTRL, 8'h00);
    $display("read test done");
    repeat (4) @(posedge core_clk);
    n_mismatch += q.size();
    tally_and_finish();
  end
  // The run needs well under 1000 cycles; this only cuts a hang.
  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
bind iap_flash_ctrl iap_flash_ctrl_checker #(.PAGE_MODE(PAGE_MODE),
  .PAGE_WORDS(PAGE_WORDS)) u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .flash_cmd(flash_cmd), .flash_rsp(flash_rsp));
`default_nettype wire
